// file: stf_pkg.sv
/*
  Shared constants and types for the sensor time counter and FIFO framer.
  Assumes a 25 MHz core clock and a 32-bit APB register port.
*/
package stf_pkg;
  // Tick period is 39.0625 us, kept in sixteenths of a microsecond.
  localparam int TICK_US_X16 = 625;
  localparam int CLK_MHZ = 25;
  localparam int PH_MOD_I = TICK_US_X16 * CLK_MHZ;
  localparam logic [13:0] PH_MOD  = 14'(PH_MOD_I);
  localparam logic [13:0] PH_STEP = 14'h0010;
  localparam int CNT_W = 24;
  localparam int FIFO_DEPTH = 1024;
  // Counter bit that toggles at 3200 Hz; each rate halving is one bit up.
  localparam logic [4:0] ODR_BIT_BASE = 5'h03;
  localparam logic [4:0] CNT_TOP_BIT  = 5'h17;
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_DATA_FIRST = 8'h0a;
  localparam logic [7:0] IDX_DATA_LAST  = 8'h17;
  localparam logic [7:0] IDX_TIME0      = 8'h18;
  localparam logic [7:0] IDX_TIME1      = 8'h19;
  localparam logic [7:0] IDX_TIME2      = 8'h1a;
  localparam logic [7:0] IDX_FIFO_LVL   = 8'h24;
  localparam logic [7:0] IDX_FIFO_DATA  = 8'h26;
  localparam logic [7:0] IDX_ACC_CFG    = 8'h40;
  localparam logic [7:0] IDX_AUX_CFG    = 8'h44;
  localparam logic [7:0] IDX_WM         = 8'h46;
  localparam logic [7:0] IDX_FIFO_CFG   = 8'h49;
  localparam logic [7:0] IDX_PWR        = 8'h7d;
  // Reset values.
  localparam logic [7:0] ACC_CFG_RST  = 8'h01;
  localparam logic [7:0] AUX_CFG_RST  = 8'h80;
  localparam logic [7:0] FIFO_CFG_RST = 8'h02;
  localparam logic [9:0] WM_RST       = 10'h000;
  localparam logic [1:0] PWR_RST      = 2'h0;
  // Field positions.
  localparam int FC_STOP = 0;
  localparam int FC_HDR  = 1;
  localparam int FC_ACC  = 2;
  localparam int FC_AUX  = 3;
  localparam int FC_DS   = 4;
  localparam int PWR_ACC = 0;
  localparam int PWR_AUX = 1;
  localparam int CF_BURST = 4;
  localparam int CONT_ACC = 0;
  localparam int CONT_AUX = 2;
  // Header encodings and frame sizes.
  localparam logic [1:0] KIND_REGULAR = 2'h2;
  localparam logic [1:0] KIND_CTRL    = 2'h1;
  localparam logic [3:0] OP_SKIP = 4'h0;
  localparam logic [3:0] OP_TIME = 4'h1;
  localparam logic [3:0] OP_CFG  = 4'h2;
  localparam logic [3:0] OP_DROP = 4'h4;
  localparam logic [3:0] ACC_BYTES = 4'h6;
  localparam logic [3:0] AUX_MAX   = 4'h8;

  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } stf_acc_t;

  typedef struct packed {
    logic [1:0] kind;
    logic [3:0] content;
    logic [1:0] tag;
  } stf_hdr_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CTRL = 5'h02,
    ST_HDR  = 5'h04,
    ST_AUX  = 5'h08,
    ST_ACC  = 5'h10
  } stf_state_t;
endpackage : stf_pkg

// file: stf_framer.sv
/*
  Sensor time counter, grid-aligned data registers and pending
  configuration, FIFO framer with 1024-byte store, APB register slave.
  Assumes sensor samples and interrupt line levels come from logic on
  the same clock, and an APB master following the usual two-phase rules.
*/
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module stf_framer (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic [9:0]       paddr_in,
  input  wire logic [31:0]      pwdata_in,
  input  wire stf_pkg::stf_acc_t acc_sample_in,
  input  wire logic [63:0]      aux_sample_in,
  input  wire logic             irq_line_one_in,
  input  wire logic             irq_line_two_in,
  output logic [31:0]           prdata_out,
  output logic                  pready_out,
  output logic                  pslverr_out,
  output logic                  fifo_full_out,
  output logic                  fifo_wm_out,
  output logic [7:0]            accel_filter_config_out,
  output logic [7:0]            aux_sensor_config_out
);
  localparam logic [10:0] DEPTH = 11'(stf_pkg::FIFO_DEPTH);

  logic [13:0]              ph_r;
  logic [23:0]              cnt_r;
  logic [23:0]              snap_r;
  logic [23:0]              tog;
  logic                     tick;
  logic [1:0]               pwr_r;
  logic [7:0]               fcfg_r;
  logic [9:0]               wm_r;
  logic [7:0]               acc_cfg_r;
  logic [7:0]               acc_pend_r;
  logic                     acc_pend_v_r;
  logic [7:0]               aux_cfg_r;
  logic [7:0]               aux_pend_r;
  logic                     aux_pend_v_r;
  logic [4:0]               acc_m;
  logic [4:0]               aux_m;
  logic [4:0]               acc_pm;
  logic [4:0]               aux_pm;
  logic [4:0]               fifo_m;
  logic                     acc_ev;
  logic                     aux_ev;
  logic                     fifo_ev;
  logic                     acc_apply;
  logic                     aux_apply;
  stf_pkg::stf_acc_t        dreg_acc_r;
  logic [63:0]              dreg_aux_r;
  logic [7:0]               idx;
  logic                     rd_take;
  logic                     wr_fire;
  logic [7:0]               rd_val;
  logic                     bad;
  logic [111:0]             dbytes;
  logic [7:0]               doff;
  logic [7:0]               mem_r [stf_pkg::FIFO_DEPTH];
  logic [9:0]               wr_ptr_r;
  logic [9:0]               rd_ptr_r;
  logic [10:0]              lvl_r;
  logic [10:0]              lvl_nxt;
  logic                     host_pop;
  logic                     ovw;
  logic                     push;
  logic [7:0]               wdata;
  stf_pkg::stf_state_t      st_r;
  stf_pkg::stf_state_t      st_nxt;
  logic [3:0]               bidx_r;
  logic                     acc_inc;
  logic                     aux_inc;
  logic [3:0]               aux_n;
  logic [4:0]               flen;
  logic                     start;
  logic                     drop;
  logic                     drop_pend_r;
  logic                     f_acc_r;
  logic                     f_aux_r;
  logic [3:0]               f_aux_n_r;
  logic [1:0]               f_tag_r;
  stf_pkg::stf_acc_t        f_acc_smp_r;
  logic [63:0]              f_aux_smp_r;
  stf_pkg::stf_hdr_t        hdr;

  // Clamp a toggle bit index to the counter's top bit.
  function automatic logic [4:0] clamp_m(input logic [5:0] m);
    clamp_m = (m > {1'b0, stf_pkg::CNT_TOP_BIT}) ?
              stf_pkg::CNT_TOP_BIT : m[4:0];
  endfunction : clamp_m

  // Fractional phase gives the exact long-run tick period at 25 MHz.
  // counter tick rate
  assign tick = (ph_r >= stf_pkg::PH_MOD - stf_pkg::PH_STEP);
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ph_r <= 14'h0000;
    end else if (tick) begin
      ph_r <= ph_r + stf_pkg::PH_STEP - stf_pkg::PH_MOD;
    end else begin
      ph_r <= ph_r + stf_pkg::PH_STEP;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 24'h000000;
    end else if (tick) begin
      cnt_r <= cnt_r + 24'h000001;
    end
  end

  // Bits that flip on this tick; a rate's event is its bit flipping.
  // grid events
  assign tog = tick ? (cnt_r ^ (cnt_r + 24'h000001)) : 24'h000000;
  assign acc_m  = clamp_m({1'b0, stf_pkg::ODR_BIT_BASE} +
                          {2'b00, acc_cfg_r[3:0]});
  assign aux_m  = clamp_m({1'b0, stf_pkg::ODR_BIT_BASE} +
                          {2'b00, aux_cfg_r[3:0]});
  assign acc_pm = clamp_m({1'b0, stf_pkg::ODR_BIT_BASE} +
                          {2'b00, acc_pend_r[3:0]});
  assign aux_pm = clamp_m({1'b0, stf_pkg::ODR_BIT_BASE} +
                          {2'b00, aux_pend_r[3:0]});
  assign acc_inc = fcfg_r[stf_pkg::FC_ACC] & pwr_r[stf_pkg::PWR_ACC];
  assign aux_inc = fcfg_r[stf_pkg::FC_AUX] & pwr_r[stf_pkg::PWR_AUX];
  // The frame rate is the faster enabled sensor, slowed by downsampling.
  assign fifo_m = clamp_m({1'b0, (acc_inc && (!aux_inc || acc_m < aux_m))
                          ? acc_m : aux_m} + {3'b000, fcfg_r[6:4]});
  assign acc_ev  = tog[acc_m] & pwr_r[stf_pkg::PWR_ACC];
  assign aux_ev  = tog[aux_m] & pwr_r[stf_pkg::PWR_AUX];
  assign fifo_ev = tog[fifo_m];

  // coinciding grid points
  // The coarser grid's toggle implies the finer one flips too.
  // same rate next event
  assign acc_apply = acc_pend_v_r & tog[(acc_m > acc_pm) ? acc_m : acc_pm];
  assign aux_apply = aux_pend_v_r & tog[(aux_m > aux_pm) ? aux_m : aux_pm];

  // Sensor data registers follow their own rate grids.
  // data register updates
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dreg_acc_r <= '0;
      dreg_aux_r <= 64'h0000000000000000;
    end else begin
      if (acc_ev) begin
        dreg_acc_r <= acc_sample_in;
      end
      if (aux_ev) begin
        dreg_aux_r <= aux_sample_in;
      end
    end
  end

  // APB decode; the answer comes one cycle into the access phase.
  assign idx     = paddr_in[9:2];
  // Data bytes in register order: aux 0 to 7, then X, Y, Z low and high.
  assign dbytes  = {dreg_acc_r, dreg_aux_r};
  assign doff    = idx - stf_pkg::IDX_DATA_FIRST;
  assign rd_take = psel_in & penable_in & ~pready_out;
  assign wr_fire = psel_in & penable_in & pready_out & pwrite_in &
                   ~pslverr_out;

  // Read mux and error decode.
  always_comb begin
    rd_val = 8'h00;
    bad    = 1'b0;
    if (paddr_in[1:0] != 2'b00) begin
      bad = 1'b1;
    end else if (idx >= stf_pkg::IDX_DATA_FIRST &&
                 idx <= stf_pkg::IDX_DATA_LAST) begin
      // aux bytes then X, Y, Z
      rd_val = dbytes[{doff[3:0], 3'b000} +: 8];
      bad    = pwrite_in;
    end else if (idx == stf_pkg::IDX_TIME0) begin
      rd_val = cnt_r[7:0];
      bad    = pwrite_in;
    end else if (idx == stf_pkg::IDX_TIME1) begin
      rd_val = snap_r[15:8];
      bad    = pwrite_in;
    end else if (idx == stf_pkg::IDX_TIME2) begin
      rd_val = snap_r[23:16];
      bad    = pwrite_in;
    end else if (idx == stf_pkg::IDX_FIFO_LVL) begin
      rd_val = lvl_r[7:0];
      bad    = pwrite_in;
    end else if (idx == stf_pkg::IDX_FIFO_DATA) begin
      rd_val = (lvl_r != 11'h000) ? mem_r[rd_ptr_r] : 8'h00;
      bad    = pwrite_in;
    end else if (idx == stf_pkg::IDX_ACC_CFG) begin
      rd_val = acc_cfg_r;
    end else if (idx == stf_pkg::IDX_AUX_CFG) begin
      rd_val = aux_cfg_r;
    end else if (idx == stf_pkg::IDX_WM) begin
      rd_val = wm_r[7:0];
    end else if (idx == stf_pkg::IDX_FIFO_CFG) begin
      rd_val = fcfg_r;
    end else if (idx == stf_pkg::IDX_PWR) begin
      rd_val = {6'h00, pwr_r};
    end else begin
      bad = 1'b1;
    end
  end

  // Answer register; fill level's upper bits ride in the high byte lanes.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end else if (rd_take) begin
      pready_out  <= 1'b1;
      pslverr_out <= bad;
      prdata_out  <= (idx == stf_pkg::IDX_FIFO_LVL ||
                      idx == stf_pkg::IDX_WM) && !bad ?
                     {21'h000000, (idx == stf_pkg::IDX_WM) ?
                      {1'b0, wm_r[9:8]} : lvl_r[10:8], rd_val} :
                     {24'h000000, rd_val};
    end else begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // coherent time snapshot
  // Reading the upper bytes alone returns the last captured value.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      snap_r <= 24'h000000;
    end else if (rd_take && !pwrite_in && !bad &&
                 idx == stf_pkg::IDX_TIME0) begin
      snap_r <= cnt_r;
    end
  end

  // Plain control registers.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwr_r  <= stf_pkg::PWR_RST;
      fcfg_r <= stf_pkg::FIFO_CFG_RST;
      wm_r   <= stf_pkg::WM_RST;
    end else if (wr_fire) begin
      if (idx == stf_pkg::IDX_PWR) begin
        pwr_r <= pwdata_in[1:0];
      end else if (idx == stf_pkg::IDX_FIFO_CFG) begin
        fcfg_r <= {1'b0, pwdata_in[6:0]};
      end else if (idx == stf_pkg::IDX_WM) begin
        wm_r <= pwdata_in[9:0];
      end
    end
  end

  // pending accel config
  // A host write wins over an apply in the same cycle; it re-arms while the accel is powered, otherwise it applies at once.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_cfg_r    <= stf_pkg::ACC_CFG_RST;
      acc_pend_r   <= stf_pkg::ACC_CFG_RST;
      acc_pend_v_r <= 1'b0;
    end else if (wr_fire && idx == stf_pkg::IDX_ACC_CFG) begin
      acc_pend_r <= pwdata_in[7:0];
      if (pwr_r[stf_pkg::PWR_ACC]) begin
        acc_pend_v_r <= 1'b1;
      end else begin
        acc_cfg_r    <= pwdata_in[7:0];
        acc_pend_v_r <= 1'b0;
      end
    end else if (acc_apply) begin
      acc_cfg_r    <= acc_pend_r;
      acc_pend_v_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aux_cfg_r    <= stf_pkg::AUX_CFG_RST;
      aux_pend_r   <= stf_pkg::AUX_CFG_RST;
      aux_pend_v_r <= 1'b0;
    end else if (wr_fire && idx == stf_pkg::IDX_AUX_CFG) begin
      aux_pend_r <= pwdata_in[7:0];
      if (pwr_r[stf_pkg::PWR_AUX]) begin
        aux_pend_v_r <= 1'b1;
      end else begin
        aux_cfg_r    <= pwdata_in[7:0];
        aux_pend_v_r <= 1'b0;
      end
    end else if (aux_apply) begin
      aux_cfg_r    <= aux_pend_r;
      aux_pend_v_r <= 1'b0;
    end
  end

  // Active configuration drives the sensor front end.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      accel_filter_config_out <= stf_pkg::ACC_CFG_RST;
      aux_sensor_config_out   <= stf_pkg::AUX_CFG_RST;
    end else begin
      accel_filter_config_out <= acc_cfg_r;
      aux_sensor_config_out   <= aux_cfg_r;
    end
  end

  assign aux_n = (aux_cfg_r[7:4] == 4'h0 ||
                  aux_cfg_r[7:4] > stf_pkg::AUX_MAX) ?
                 stf_pkg::AUX_MAX : aux_cfg_r[7:4];
  assign flen  = {4'h0, fcfg_r[stf_pkg::FC_HDR]} +
                 (aux_inc ? {1'b0, aux_n} : 5'h00) +
                 (acc_inc ? {1'b0, stf_pkg::ACC_BYTES} : 5'h00) +
                 {4'h0, drop_pend_r & fcfg_r[stf_pkg::FC_HDR]};
  assign start = fifo_ev & (st_r == stf_pkg::ST_IDLE) & (acc_inc | aux_inc);
  assign drop  = start & fcfg_r[stf_pkg::FC_STOP] &
                 ((DEPTH - lvl_r) < {6'h00, flen});

  // Frame state machine.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      stf_pkg::ST_IDLE: begin
        if (start && !drop) begin
          if (drop_pend_r && fcfg_r[stf_pkg::FC_HDR]) begin
            st_nxt = stf_pkg::ST_CTRL;
          end else if (fcfg_r[stf_pkg::FC_HDR]) begin
            st_nxt = stf_pkg::ST_HDR;
          end else if (aux_inc) begin
            st_nxt = stf_pkg::ST_AUX;
          end else begin
            st_nxt = stf_pkg::ST_ACC;
          end
        end
      end
      stf_pkg::ST_CTRL: begin
        st_nxt = stf_pkg::ST_HDR;
      end
      stf_pkg::ST_HDR: begin
        st_nxt = f_aux_r ? stf_pkg::ST_AUX : stf_pkg::ST_ACC;
      end
      stf_pkg::ST_AUX: begin
        if (bidx_r == f_aux_n_r - 4'h1) begin
          st_nxt = f_acc_r ? stf_pkg::ST_ACC : stf_pkg::ST_IDLE;
        end
      end
      stf_pkg::ST_ACC: begin
        if (bidx_r == stf_pkg::ACC_BYTES - 4'h1) begin
          st_nxt = stf_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = stf_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r   <= stf_pkg::ST_IDLE;
      bidx_r <= 4'h0;
    end else begin
      st_r   <= st_nxt;
      bidx_r <= (st_nxt == st_r) ? bidx_r + 4'h1 : 4'h0;
    end
  end

  // Sample and frame shape are frozen at the frame's start.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      f_acc_r     <= 1'b0;
      f_aux_r     <= 1'b0;
      f_aux_n_r   <= stf_pkg::AUX_MAX;
      f_tag_r     <= 2'b00;
      f_acc_smp_r <= '0;
      f_aux_smp_r <= 64'h0000000000000000;
    end else if (start && !drop) begin
      f_acc_r     <= acc_inc;
      f_aux_r     <= aux_inc;
      f_aux_n_r   <= aux_n;
      f_tag_r     <= {irq_line_two_in, irq_line_one_in};
      f_acc_smp_r <= acc_sample_in;
      f_aux_smp_r <= aux_sample_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drop_pend_r <= 1'b0;
    end else if (drop && fcfg_r[stf_pkg::FC_HDR]) begin
      drop_pend_r <= 1'b1;
    end else if (st_r == stf_pkg::ST_CTRL) begin
      drop_pend_r <= 1'b0;
    end
  end

  always_comb begin
    hdr = '0;
    hdr.kind = stf_pkg::KIND_REGULAR;
    hdr.content[stf_pkg::CONT_AUX] = f_aux_r;
    hdr.content[stf_pkg::CONT_ACC] = f_acc_r;
    hdr.tag = f_tag_r;
  end

  // Byte going into the store this cycle.
  assign push = (st_r != stf_pkg::ST_IDLE);
  always_comb begin
    case (st_r)
      stf_pkg::ST_CTRL: wdata = {stf_pkg::KIND_CTRL, stf_pkg::OP_DROP, 2'b00};
      stf_pkg::ST_HDR:  wdata = hdr;
      stf_pkg::ST_AUX:  wdata = f_aux_smp_r[{bidx_r[2:0], 3'b000} +: 8];
      stf_pkg::ST_ACC:  wdata = f_acc_smp_r[{bidx_r[2:0], 3'b000} +: 8];
      default:          wdata = 8'h00;
    endcase
  end

  assign host_pop = rd_take & ~pwrite_in & ~bad &
                    (idx == stf_pkg::IDX_FIFO_DATA) & (lvl_r != 11'h000);
  assign ovw = push & (lvl_r == DEPTH) & ~host_pop;
  assign lvl_nxt = lvl_r + {10'h000, push} - {10'h000, host_pop | ovw};

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= wdata;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= 10'h000;
      rd_ptr_r <= 10'h000;
      lvl_r    <= 11'h000;
    end else begin
      wr_ptr_r <= wr_ptr_r + {9'h000, push};
      rd_ptr_r <= rd_ptr_r + {9'h000, host_pop | ovw};
      lvl_r    <= lvl_nxt;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fifo_full_out <= 1'b0;
      fifo_wm_out   <= 1'b0;
    end else begin
      fifo_full_out <= (lvl_nxt == DEPTH);
      fifo_wm_out   <= (wm_r != 10'h000) && (lvl_nxt >= {1'b0, wm_r});
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  AST_TIME_STEP: assert property (
    tick |=> cnt_r == $past(cnt_r) + 24'h1 || cnt_r == 24'h0)
    else $error("time counter missed a step");
  AST_TIME_WRAP: assert property (
    tick && cnt_r == 24'hffffff |=> cnt_r == 24'h000000)
    else $error("time counter did not wrap");
  AST_SNAP_HOLD: assert property (
    !(rd_take && idx == stf_pkg::IDX_TIME0) |=> $stable(snap_r))
    else $error("time snapshot moved mid burst");
  AST_ACC_GRID: assert property (
    $changed(dreg_acc_r) |-> $past(tog[acc_m]))
    else $error("data update off grid");
  AST_PEND_HOLD: assert property (
    acc_pend_v_r && !acc_apply && !wr_fire |=> $stable(acc_cfg_r))
    else $error("pending config applied early");
  AST_PEND_APPLY: assert property (
    acc_apply && !wr_fire
    |=> acc_cfg_r == $past(acc_pend_r) && !acc_pend_v_r)
    else $error("pending config not applied");
  // The largest header-mode frame behind a drop marker is 16 bytes, idle by cycle 17.
  AST_STOP_FULL: assert property (
    fcfg_r[stf_pkg::FC_STOP] && start && !drop
    |-> ##[1:17] st_r == stf_pkg::ST_IDLE && !ovw)
    else $error("stop mode frame overflowed");
  AST_HDR_FMT: assert property (
    st_r == stf_pkg::ST_HDR
    |-> wdata[7:6] == stf_pkg::KIND_REGULAR && wdata[5:2] != 4'h0)
    else $error("bad regular header");
  AST_FIFO_EN: assert property (
    start && !drop |=> (f_acc_r | f_aux_r) && st_r != stf_pkg::ST_IDLE)
    else $error("frame without enabled sensor");
  AST_POP: assert property (
    host_pop |=> lvl_r == $past(lvl_r) + {10'h0, $past(push)} - 11'h1)
    else $error("host read did not remove a byte");

  COV_FRAME: cover property (st_r == stf_pkg::ST_HDR ##1
    st_r == stf_pkg::ST_AUX);
  COV_OVW: cover property (ovw);
  // The pending flag remembers the drop, so no long delay range is needed.
  COV_DROP: cover property (drop_pend_r && st_r == stf_pkg::ST_CTRL);
  COV_APPLY: cover property (acc_apply);
endmodule : stf_framer

// file: stf_sensor_model.sv
/* Sensor-side source: steady samples and interrupt levels.
   Assumes the framer samples them on the bench clock. */
`timescale 1ns/100ps
module stf_sensor_model (
  output stf_pkg::stf_acc_t acc_out,
  output logic [63:0]       aux_out,
  output logic              irq_one_out,
  output logic              irq_two_out
);
  // Fixed sample values, so every payload byte is known in advance.
  assign acc_out = '{z: 16'h9abc, y: 16'h5678, x: 16'h1234};
  assign aux_out = 64'h0f0e0d0c0b0a0908;
  // Both lines are held high, so every tag field reads 2'h3.
  assign irq_one_out = 1'b1;
  assign irq_two_out = 1'b1;
endmodule : stf_sensor_model

// file: stf_framer_tb.sv
/* Bench for the framer: APB host tasks and checked sequences.
   Assumes the sensor model drives steady samples. */
`timescale 1ns/100ps
module stf_framer_tb;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              psel = 1'b0;
  logic              pen = 1'b0;
  logic              pwr = 1'b0;
  logic              err;
  logic [9:0]        paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       q;
  logic [23:0]       ts [2];
  logic [31:0]       prdata;
  logic              pready;
  logic              perr;
  logic              full;
  logic              wm;
  logic [7:0]        acfg;
  logic [7:0]        xcfg;
  logic [63:0]       aux;
  logic              i1;
  logic              i2;
  stf_pkg::stf_acc_t acc;
  int                num_errors = 0;
  int                num_checks = 0;
  logic [7:0]        fr [7] = '{8'h87, 8'h34, 8'h12, 8'h78, 8'h56,
                                8'hbc, 8'h9a};

  // Free-running 25 MHz clock.
  always #20 clk = ~clk;

  stf_sensor_model SRC (.acc_out(acc), .aux_out(aux),
    .irq_one_out(i1), .irq_two_out(i2));

  stf_framer DUT (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .acc_sample_in(acc), .aux_sample_in(aux),
    .irq_line_one_in(i1), .irq_line_two_in(i2), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(perr), .fifo_full_out(full),
    .fifo_wm_out(wm), .accel_filter_config_out(acfg),
    .aux_sensor_config_out(xcfg));

  // Compare and count; an unknown never matches.
  task automatic chk(input string n, input logic [31:0] e, s);
    num_checks++;
    if (s !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, s);
      num_errors++;
    end
  endtask : chk

  // One APB transfer; an edge passes first so strobes never collide.
  task automatic xfer(input logic w, input logic [7:0] i,
                      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : xfer

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Watchdog sized well above the slowest grid waits.
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    test_done;
  end

  // Main sequence of register, pending-config and frame checks.
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    chk("aux_cfg_rst", 32'h80, xcfg);
    xfer(0, stf_pkg::IDX_FIFO_CFG, 0);
    chk("fifo_cfg", 32'h02, q);
    xfer(0, 8'h7f, 0);
    chk("unmapped", 1, err);
    xfer(1, stf_pkg::IDX_DATA_FIRST, 0);
    chk("ro_write", 1, err);
    xfer(1, stf_pkg::IDX_ACC_CFG, 0);
    repeat (2) @(posedge clk);
    chk("acc_now", 0, acfg);
    xfer(1, stf_pkg::IDX_PWR, 1);
    xfer(1, stf_pkg::IDX_ACC_CFG, 1);
    repeat (2) @(posedge clk);
    chk("acc_held", 0, acfg);
    for (int k = 0; k < 20000 && acfg !== 8'h01; k++) @(posedge clk);
    chk("acc_applied", 1, acfg);
    xfer(1, stf_pkg::IDX_WM, 1);
    xfer(1, stf_pkg::IDX_FIFO_CFG, 32'h06);
    do xfer(0, stf_pkg::IDX_FIFO_LVL, 0); while (q < 7);
    chk("wm", 1, wm);
    chk("full", 0, full);
    for (int k = 0; k < 7; k++) begin
      xfer(0, stf_pkg::IDX_FIFO_DATA, 0);
      chk("fifo_byte", fr[k], q[7:0]);
    end
    xfer(0, stf_pkg::IDX_DATA_FIRST + 8'h08, 0);
    chk("data_xl", 8'h34, q[7:0]);
    for (int j = 0; j < 2; j++) begin
      for (int k = 0; k < 3; k++) begin
        xfer(0, stf_pkg::IDX_TIME0 + 8'(k), 0);
        ts[j][8*k +: 8] = q[7:0];
      end
      repeat (3000) @(posedge clk);
    end
    chk("time_moves", 1, 32'(ts[1] > ts[0]));
    test_done;
  end
endmodule : stf_framer_tb
